// ### hw/spw_cfg.svh
`ifndef SPW_CFG_SVH
`define SPW_CFG_SVH

// register byte offsets on the apb bus
`define SPW_A_REQ0 8'h00
`define SPW_A_REQ1 8'h04
`define SPW_A_CTRL 8'h08
`define SPW_A_ERRC 8'h0c
`define SPW_A_RSP0 8'h10
`define SPW_A_RSP1 8'h14
`define SPW_A_STAT 8'h18
`define SPW_A_BADDR 8'h1c
`define SPW_A_BDATA 8'h20
`define SPW_A_PADDR 8'h24

// control register bit positions
`define SPW_CTRL_GO 0
`define SPW_CTRL_FAULT 1

// service byte layout and codes
`define SPW_HS_BIT 6
`define SPW_ERR_BIT 7
`define SPW_RSV_BIT 3
`define SPW_EXT 3'h4
`define SPW_RT_INIT 2'h2
`define SPW_RT_SEG 2'h3
`define SPW_RT_SEG_ALT 2'h1
`define SPW_SVC_OK 6'h04
`define SPW_SVC_ERR 6'h30

// parameter and segment limits
`define SPW_MAX_LEN 8'h80
`define SPW_SEG_MAX 3'h6

// error codes placed in bytes 5 to 8 of a drive abort
`define SPW_EC_NONE 32'h0000_0000
`define SPW_EC_LEN 32'h0000_0001
`define SPW_EC_SEQ 32'h0000_0002
`define SPW_EC_SEG 32'h0000_0003
`define SPW_EC_UNSUP 32'h0000_0004

// reset values
`define SPW_RST_WORD 32'h0000_0000
`define SPW_RST_BYTE 8'h00

`endif

// ### hw/spw_pkg.sv
package spw_pkg;
   typedef logic [31:0] spw_word_t;
   typedef logic [63:0] spw_msg_t;
   typedef logic [7:0] spw_addr_t;
   // write sequence states, one-hot
   typedef enum logic [2:0] {
      SPW_IDLE = 3'b001,
      SPW_OPEN = 3'b010,
      SPW_STORE = 3'b100
   } spw_state_t;
endpackage : spw_pkg

// ### hw/spw_mem_if.sv
interface spw_mem_if;
   logic we;
   logic [6:0] waddr;
   logic [7:0] wdata;
   logic [6:0] raddr;
   logic [7:0] rdata;
   modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
   modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : spw_mem_if

// ### hw/spw_mem.sv
module spw_mem (
   input wire logic pclk,
   spw_mem_if.mem port
);
   logic [7:0] arr [128];

   // one byte written per cycle, read data registered
   always_ff @(posedge pclk) begin
      if (port.we) begin
         arr[port.waddr] <= port.wdata;
      end
      port.rdata <= arr[port.raddr];
   end
endmodule : spw_mem

// ### hw/spw_top.sv
// The APB slave port and the register offsets were left to the implementer.
`include "spw_cfg.svh"

// Overview of operation
// - parameter at most 128 bytes long
// - handshake bit toggles on every message
// - reserved service bit 3 sent as zero
// - error bit clear in normal messages
// - initiate answer 44/04, echoes address, zeros
// - valid bytes fill front, only those taken
// - segment answer 44/04, all other bytes zero
// - drive abort F0/B0 with error code
// - abort discards all received data
module spw_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire spw_pkg::spw_addr_t paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire spw_pkg::spw_word_t pwdata,
   output spw_pkg::spw_word_t prdata,
   output logic pready,
   output logic pslverr
);
   import spw_pkg::*;

   spw_mem_if mif ();

   spw_word_t req0_q, req1_q, errc_q, rdata_q;
   spw_msg_t rsp_q, rsp_d;
   spw_state_t state_q, state_d;
   logic go_q, fault_q, hs_q, valid_q, last_q;
   logic [7:0] sub_q, len_q, cnt_q;
   logic [15:0] idx_q;
   logic [6:0] baddr_q;
   logic [2:0] nleft_q;
   logic [47:0] dat_q;
   logic rsp_load, discard, open_load, seg_load;

   spw_mem u_mem (
      .pclk (pclk),
      .port (mif.mem)
   );

   // apb decode; the slave never waits, unmapped addresses answer pslverr
   wire apb_acc = psel & penable;
   wire apb_wr = apb_acc & pwrite;
   wire apb_setup = psel & ~penable;
   wire hit_req0 = paddr == `SPW_A_REQ0;
   wire hit_req1 = paddr == `SPW_A_REQ1;
   wire hit_ctrl = paddr == `SPW_A_CTRL;
   wire hit_errc = paddr == `SPW_A_ERRC;
   wire hit_baddr = paddr == `SPW_A_BADDR;
   wire hit_ro = paddr == `SPW_A_RSP0 || paddr == `SPW_A_RSP1 || paddr == `SPW_A_STAT ||
                 paddr == `SPW_A_BDATA || paddr == `SPW_A_PADDR;
   wire hit_any = hit_req0 | hit_req1 | hit_ctrl | hit_errc | hit_baddr | hit_ro;
   assign pready = 1'b1;
   assign pslverr = apb_acc & ~hit_any;
   assign prdata = rdata_q;

   // go is refused while a segment is still being stored
   wire busy = go_q | (state_q == SPW_STORE);
   wire go_wr = apb_wr & hit_ctrl & pwdata[`SPW_CTRL_GO] & ~busy;

   // request decode from the message registers
   wire [7:0] svc = req0_q[31:24];
   wire [7:0] ctl = req0_q[23:16];
   wire hs_in = svc[`SPW_HS_BIT];
   wire ext = svc[2:0] == `SPW_EXT;
   wire plain = ext & ~svc[`SPW_ERR_BIT] & ~svc[`SPW_RSV_BIT];
   wire is_abort = ext & svc[`SPW_ERR_BIT];
   wire is_init = plain & (svc[5:4] == `SPW_RT_INIT);
   wire is_seg = plain & (svc[5:4] == `SPW_RT_SEG || svc[5:4] == `SPW_RT_SEG_ALT);
   wire new_msg = go_q & (hs_in != hs_q);

   wire len_bad = req1_q == 32'h0 || req1_q > {24'h0, `SPW_MAX_LEN};
   wire [2:0] nnn = ctl[3:1];
   wire [7:0] cnt_sum = cnt_q + {5'h0, nnn};
   wire ctl_bad = nnn == 3'h0 || nnn > `SPW_SEG_MAX || ctl[7:4] != 4'h0;
   wire seg_bad = ctl_bad || cnt_sum > len_q || (ctl[0] && cnt_sum != len_q);
   wire is_open = state_q == SPW_OPEN;

   // service byte of an answer: handshake echoed, error or success form
   // answer service bits
   function automatic logic [7:0] svc_byte(input logic hs, input logic err);
      svc_byte = err ? {1'b1, hs, `SPW_SVC_ERR} : {1'b0, hs, `SPW_SVC_OK};
   endfunction : svc_byte

   // sequence decisions for a taken request and for the store walk
   always_comb begin
      state_d = state_q;
      rsp_d = rsp_q;
      rsp_load = 1'b0;
      discard = 1'b0;
      open_load = 1'b0;
      seg_load = 1'b0;
      unique case (state_q)
         SPW_IDLE, SPW_OPEN: begin
            if (new_msg) begin
               rsp_load = 1'b1;
               if (is_abort) begin
                  rsp_d = {svc_byte(hs_in, 1'b1), 24'h0, `SPW_EC_NONE};
                  discard = 1'b1;
                  state_d = SPW_IDLE;
               end else if (is_open && fault_q) begin
                  rsp_d = {svc_byte(hs_in, 1'b1), sub_q, idx_q, errc_q};
                  discard = 1'b1;
                  state_d = SPW_IDLE;
               end else if (is_init && len_bad) begin
                  rsp_d = {svc_byte(hs_in, 1'b1), req0_q[23:0], `SPW_EC_LEN};
                  discard = 1'b1;
                  state_d = SPW_IDLE;
               end else if (is_init) begin
                  rsp_d = {svc_byte(hs_in, 1'b0), req0_q[23:0], 32'h0};
                  open_load = 1'b1;
                  state_d = SPW_OPEN;
               end else if (is_seg && !is_open) begin
                  rsp_d = {svc_byte(hs_in, 1'b1), sub_q, idx_q, `SPW_EC_SEQ};
               end else if (is_seg && seg_bad) begin
                  rsp_d = {svc_byte(hs_in, 1'b1), sub_q, idx_q, `SPW_EC_SEG};
                  discard = 1'b1;
                  state_d = SPW_IDLE;
               end else if (is_seg) begin
                  // answer waits until the bytes are stored
                  rsp_load = 1'b0;
                  seg_load = 1'b1;
                  state_d = SPW_STORE;
               end else begin
                  rsp_d = {svc_byte(hs_in, 1'b1), sub_q, idx_q, `SPW_EC_UNSUP};
               end
            end
         end
         SPW_STORE: begin
            if (nleft_q == 3'h1) begin
               rsp_load = 1'b1;
               rsp_d = {svc_byte(hs_q, 1'b0), 56'h0};
               state_d = last_q ? SPW_IDLE : SPW_OPEN;
            end
         end
         default: begin
            state_d = SPW_IDLE;
         end
      endcase
   end

   // memory port: store walk writes one byte a cycle at the fill count
   assign mif.we = state_q == SPW_STORE;
   assign mif.waddr = cnt_q[6:0];
   assign mif.wdata = dat_q[47:40];
   assign mif.raddr = baddr_q;

   // apb writable registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req0_q <= `SPW_RST_WORD;
         req1_q <= `SPW_RST_WORD;
         errc_q <= `SPW_RST_WORD;
         baddr_q <= 7'h0;
         go_q <= 1'b0;
      end else begin
         if (apb_wr && hit_req0) req0_q <= pwdata;
         if (apb_wr && hit_req1) req1_q <= pwdata;
         if (apb_wr && hit_errc) errc_q <= pwdata;
         if (apb_wr && hit_baddr) baddr_q <= pwdata[6:0];
         go_q <= go_wr;
      end
   end

   // fault arm: a fresh arm wins over the clear by the abort it causes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_q <= 1'b0;
      end else if (apb_wr && hit_ctrl && pwdata[`SPW_CTRL_FAULT]) begin
         fault_q <= 1'b1;
      end else if (discard) begin
         fault_q <= 1'b0;
      end
   end

   // sequence state, handshake and answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= SPW_IDLE;
         hs_q <= 1'b0;
         rsp_q <= 64'h0;
      end else begin
         state_q <= state_d;
         if (new_msg) hs_q <= hs_in;
         if (rsp_load) rsp_q <= rsp_d;
      end
   end

   // parameter address, length, fill count and validity
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sub_q <= `SPW_RST_BYTE;
         idx_q <= 16'h0;
         len_q <= `SPW_RST_BYTE;
         cnt_q <= `SPW_RST_BYTE;
         valid_q <= 1'b0;
      end else if (discard || open_load) begin
         cnt_q <= `SPW_RST_BYTE;
         valid_q <= 1'b0;
         if (open_load) begin
            sub_q <= req0_q[23:16];
            idx_q <= req0_q[15:0];
            len_q <= req1_q[7:0];
         end
      end else if (state_q == SPW_STORE) begin
         cnt_q <= cnt_q + 8'h01;
         if (nleft_q == 3'h1 && last_q) valid_q <= 1'b1;
      end
   end

   // segment latch; bytes leave from the front
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dat_q <= 48'h0;
         nleft_q <= 3'h0;
         last_q <= 1'b0;
      end else if (seg_load) begin
         dat_q <= {req0_q[15:0], req1_q};
         nleft_q <= nnn;
         last_q <= ctl[0];
      end else if (state_q == SPW_STORE) begin
         dat_q <= {dat_q[39:0], 8'h00};
         nleft_q <= nleft_q - 3'h1;
      end
   end

   // read mux, sampled in the setup phase so prdata comes from a flop
   wire [31:0] stat_w = {8'h0, len_q, cnt_q, 3'h0, fault_q, hs_q, valid_q, is_open, busy};
   wire [31:0] bdata_w = {24'h0, valid_q ? mif.rdata : 8'h00};
   wire [31:0] rd_mux = hit_req0 ? req0_q :
                        hit_req1 ? req1_q :
                        hit_ctrl ? {30'h0, fault_q, 1'b0} :
                        hit_errc ? errc_q :
                        paddr == `SPW_A_RSP0 ? rsp_q[63:32] :
                        paddr == `SPW_A_RSP1 ? rsp_q[31:0] :
                        paddr == `SPW_A_STAT ? stat_w :
                        hit_baddr ? {25'h0, baddr_q} :
                        paddr == `SPW_A_BDATA ? bdata_w :
                        paddr == `SPW_A_PADDR ? {8'h0, sub_q, idx_q} : 32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= `SPW_RST_WORD;
      end else if (apb_setup) begin
         rdata_q <= rd_mux;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_len_limit:
   assert property (cnt_q <= `SPW_MAX_LEN && (!valid_q || cnt_q == len_q))
      else $error("fill count beyond parameter limit");
   a_hs_echo:
   assert property (new_msg && !is_seg |=> rsp_q[62] == $past(hs_in))
      else $error("answer handshake does not echo request");
   a_rsv_zero:
   assert property (rsp_q[59] == 1'b0)
      else $error("reserved service bit set in answer");
   a_ok_no_err:
   assert property (rsp_load && rsp_d[61:56] == `SPW_SVC_OK |=> !rsp_q[63])
      else $error("error bit set in success answer");
   a_init_answer:
   assert property (new_msg && is_init && !len_bad && !(is_open && fault_q)
                    |=> rsp_q[61:56] == `SPW_SVC_OK && rsp_q[55:32] == $past(req0_q[23:0]) && rsp_q[31:0] == 32'h0)
      else $error("initiate answer malformed");
   a_seg_store:
   assert property (seg_load |=> (mif.we && mif.waddr == $past(cnt_q[6:0])) [*1] ##0 nleft_q == $past(nnn))
      else $error("segment store does not start at fill count");
   a_seg_answer:
   assert property (state_q == SPW_STORE && nleft_q == 3'h1
                    |=> rsp_q[63:56] == {1'b0, hs_q, `SPW_SVC_OK} && rsp_q[55:0] == 56'h0)
      else $error("segment answer malformed");
   a_drv_abort:
   assert property (new_msg && !is_abort && is_open && fault_q
                    |=> rsp_q[63:56] == {1'b1, $past(hs_in), `SPW_SVC_ERR} && rsp_q[31:0] == $past(errc_q))
      else $error("drive abort answer malformed");
   a_abort_discard:
   assert property (discard |=> !valid_q && cnt_q == 8'h00 && state_q == SPW_IDLE)
      else $error("abort did not discard data");

   c_init_ok: cover property (new_msg && is_init && !len_bad);
   c_final_seg: cover property (state_q == SPW_STORE && nleft_q == 3'h1 && last_q);
   c_master_abort: cover property (new_msg && is_abort && is_open);
endmodule : spw_top

// ### test/spw_apb_master.sv
module spw_apb_master (
   input wire logic pclk,
   output spw_pkg::spw_addr_t paddr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output spw_pkg::spw_word_t pwdata,
   input wire spw_pkg::spw_word_t prdata,
   input wire logic pready,
   input wire logic pslverr
);
   timeunit 1ns;
   timeprecision 1ns;
   import spw_pkg::*;

   // bus idle at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end

   // one transfer: setup, access held until pready, release after that edge
   // one request at a time
   task automatic xfer(input logic wr, input spw_addr_t a, input spw_word_t d,
                       output spw_word_t q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines stop showing the old value
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer
endmodule : spw_apb_master

// ### test/spw_top_tb_top.sv
`include "spw_cfg.svh"
module spw_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import spw_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel;
   logic penable;
   logic pwrite;
   logic pready;
   logic pslverr;
   spw_addr_t paddr;
   spw_word_t pwdata;
   spw_word_t prdata;
   int err_total = 0;
   int comparisons = 0;
   logic hs = 1'b0;
   spw_msg_t rsp;

   // 10 mhz clock
   always #50 pclk = ~pclk;

   spw_top u_spw_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   spw_apb_master u_spw_apb_master (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic close_out();
      $display("mismatches %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out

   task automatic wr(input spw_addr_t a, input spw_word_t d);
      spw_word_t q;
      logic e;
      u_spw_apb_master.xfer(1'b1, a, d, q, e);
   endtask : wr

   task automatic rd(input spw_addr_t a, output spw_word_t q);
      logic e;
      u_spw_apb_master.xfer(1'b0, a, 32'h0000_0000, q, e);
   endtask : rd

   // one message; svc comes with its handshake bit clear, keep repeats the last one
   task automatic send(input logic [7:0] svc, input logic [55:0] body, input logic keep);
      spw_word_t r0;
      spw_word_t r1;
      spw_word_t st;
      if (!keep) hs = ~hs;
      wr(`SPW_A_REQ0, {svc | {1'b0, hs, 6'h00}, body[55:32]});
      wr(`SPW_A_REQ1, body[31:0]);
      wr(`SPW_A_CTRL, 32'h0000_0001);
      // wait for matching answer; only the watchdog ends a hang
      do begin
         rd(`SPW_A_STAT, st);
         rd(`SPW_A_RSP0, r0);
      end while (st[0] !== 1'b0 || r0[30] !== hs);
      rd(`SPW_A_RSP1, r1);
      rsp = {r0, r1};
   endtask : send

   task automatic t_reset();
      spw_word_t q;
      logic e;
      rd(`SPW_A_STAT, q);
      chk("stat reset", q, 32'h0000_0000);
      rd(`SPW_A_RSP0, q);
      chk("rsp0 reset", q, 32'h0000_0000);
      chk("pready", pready, 1'b1);
      u_spw_apb_master.xfer(1'b1, `SPW_A_BADDR, 32'h0000_0000, q, e);
      chk("mapped", e, 1'b0);
      u_spw_apb_master.xfer(1'b0, 8'h40, 32'h0000_0000, q, e);
      chk("unmapped", e, 1'b1);
      chk("unmapped data", q, 32'h0000_0000);
   endtask : t_reset

   task automatic t_write();
      spw_word_t q;
      send(8'h24, {8'h11, 16'h2233, 32'h0000_000a}, 1'b0);
      chk("init answer", rsp, {1'b0, hs, `SPW_SVC_OK, 8'h11, 16'h2233, 32'h0});
      send(8'h34, {8'h0c, 48'ha0a1_a2a3_a4a5}, 1'b0);
      chk("seg answer", rsp, {1'b0, hs, `SPW_SVC_OK, 56'h0});
      send(8'h34, {8'h0c, 48'hdead_dead_dead}, 1'b1);
      rd(`SPW_A_STAT, q);
      chk("dup ignored", q[15:8], 8'h06);
      // last segment of four bytes, printed code 01
      send(8'h14, {8'h09, 48'hb0b1_b2b3_eeee}, 1'b0);
      chk("last answer", rsp, {1'b0, hs, `SPW_SVC_OK, 56'h0});
      rd(`SPW_A_STAT, q);
      chk("stat done", {q[23:8], q[3], q[2]}, {8'h0a, 8'h0a, hs, 1'b1});
      rd(`SPW_A_PADDR, q);
      chk("param addr", q, 32'h0011_2233);
      for (int i = 0; i < 10; i++) begin
         wr(`SPW_A_BADDR, 32'(i));
         rd(`SPW_A_BDATA, q);
         chk("stored byte", q, (i < 6) ? 32'(8'ha0 + i) : 32'(8'hb0 + i - 6));
      end
   endtask : t_write

   task automatic t_errors();
      spw_word_t q;
      send(8'h24, {8'h11, 16'h2233, 32'h0000_0081}, 1'b0);
      chk("len err", rsp, {1'b1, hs, `SPW_SVC_ERR, 8'h11, 16'h2233, `SPW_EC_LEN});
      send(8'h2c, {8'h11, 16'h2233, 32'h0000_0004}, 1'b0);
      chk("rsv err", {rsp[63:56], rsp[31:0]}, {1'b1, hs, `SPW_SVC_ERR, `SPW_EC_UNSUP});
      send(8'h34, {8'h0c, 48'h0}, 1'b0);
      chk("seq err", {rsp[63:56], rsp[31:0]}, {1'b1, hs, `SPW_SVC_ERR, `SPW_EC_SEQ});
      send(8'h24, {8'h05, 16'h0607, 32'h0000_0080}, 1'b0);
      chk("len 128", rsp, {1'b0, hs, `SPW_SVC_OK, 8'h05, 16'h0607, 32'h0});
      send(8'h34, {8'h0c, 48'h0102_0304_0506}, 1'b0);
      send(8'h84, 56'h0, 1'b0);
      chk("abort answer", rsp, {1'b1, hs, `SPW_SVC_ERR, 56'h0});
      rd(`SPW_A_STAT, q);
      chk("abort drop", {q[15:8], q[1]}, {8'h00, 1'b0});
      // armed internal fault hits the next segment
      send(8'h24, {8'h05, 16'h0607, 32'h0000_0004}, 1'b0);
      wr(`SPW_A_ERRC, 32'h0000_0abc);
      wr(`SPW_A_CTRL, 32'h0000_0002);
      rd(`SPW_A_CTRL, q);
      chk("fault armed", q, 32'h0000_0002);
      send(8'h34, {8'h08, 48'h0}, 1'b0);
      chk("fault abort", {rsp[63:56], rsp[31:0]}, {1'b1, hs, `SPW_SVC_ERR, 32'h0000_0abc});
      rd(`SPW_A_STAT, q);
      chk("fault drop", {q[15:8], q[4], q[1]}, {8'h00, 1'b0, 1'b0});
   endtask : t_errors

   // reset for eight cycles, then the scenarios
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_write();
      t_errors();
      close_out();
   end

   // the run needs a few hundred cycles; this leaves wide margin
   initial begin
      repeat (20000) @(posedge pclk);
      err_total++;
      close_out();
   end
endmodule : spw_top_tb_top
